// ---- logic/clock_trim_sync_config.sv ----
// register and sync front end of the oscillator trim unit
// What this block does
// RL1: run bit stops or runs counter, resets stopped
// RL2: bit 3 gates expected sync interrupt
// RL3: bit 2 gates error interrupt
// RL4: bit 1 gates trim warning interrupt
// RL5: bit 0 gates trim done interrupt
// RL6: config register accessed by whole words only
// RL7: config writes ignored while counter runs
// RL8: bit 31 picks rising or falling edge
// RL9: selector picks pin or crystal, 11 as 00
// RL10: prescaler divides sync by two to code
// RL11: eight bit window limit, reset 0x22
// RL12: sixteen bit reload loaded on sync pulse
// RL13: run bit sits at bit 5, software set
// RL14: lost sync at 128 times limit, flagged
// RL15: interrupt is OR of enabled flags
module clock_trim_sync_config
  import trim_cfg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [trim_cfg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // reference pins, asynchronous
  input wire logic i_sync_pin,
  input wire logic i_low_speed_crystal,
  // events from the trim algorithm, core clock pulses
  input wire logic i_trim_done_ev,
  input wire logic i_trim_warn_ev,
  input wire logic i_trim_range_ev,
  input wire logic i_expected_sync_ev,
  // to the rest of the unit
  output logic o_counter_run,
  output logic [15:0] o_counter_reload,
  output logic [7:0] o_window_limit,
  output logic o_sync_pulse,
  output logic [15:0] o_counter,
  output logic o_counter_up,
  output logic [3:0] o_irq_en,
  // interrupt
  output logic o_irq
);
  logic [31:0] run_ctrl_reg;
  logic [31:0] sync_cfg_reg;
  logic [N_EV-1:0] stat_reg;
  logic [N_EV-1:0] mask_reg;
  logic [N_EV-1:0] ev_set;
  logic [1:0] pin_sync_reg;
  logic [1:0] xtal_sync_reg;
  logic sel_ref;
  logic sync_pulse;
  logic [15:0] cnt_reg;
  logic up_reg;
  logic [15:0] lost_cnt_reg;
  logic lost_hit;
  logic [1:0] src;
  logic run;
  logic [15:0] lost_top;

  assign run = run_ctrl_reg[COUNTER_RUN_BIT];
  assign src = sync_cfg_reg[SRC_LSB +: 2];
  assign lost_top = 16'(LOST_MULT * sync_cfg_reg[WLIM_LSB +: 8]); // RL14

  // run control register, bit 5 run, bits 3..0 enables
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      run_ctrl_reg <= RUN_CTRL_RST; // RL1
    end else if (i_wr && i_addr == RUN_CTRL_OFF) begin
      run_ctrl_reg <= i_wdata & RUN_CTRL_WMASK; // RL13
    end
  end

  // the port carries only whole words, so partial access cannot arise
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_cfg_reg <= SYNC_CFG_RST; // RL11
    end else if (i_wr && i_addr == SYNC_CFG_OFF && !run) begin // RL7 RL6
      sync_cfg_reg <= i_wdata & SYNC_CFG_WMASK;
    end
  end

  // two flops on each pin before any logic
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_sync_reg <= 2'h0;
      xtal_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], i_sync_pin};
      xtal_sync_reg <= {xtal_sync_reg[0], i_low_speed_crystal};
    end
  end

  // reserved code selects nothing, so no pulses appear after reset
  always_comb begin
    case (src)
      SRC_PIN: sel_ref = pin_sync_reg[1]; // RL9
      SRC_CRYSTAL: sel_ref = xtal_sync_reg[1];
      SRC_PIN_ALT: sel_ref = pin_sync_reg[1];
      default: sel_ref = 1'b0;
    endcase
  end

  sync_divider_unit u_div (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(run),
    .i_edge_sel(sync_cfg_reg[EDGE_BIT]),
    .i_div_code(sync_cfg_reg[DIV_LSB +: 3]),
    .i_ref(sel_ref),
    .o_pulse(sync_pulse)
  );

  // calibration counter: reload on pulse, down to zero then up
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 16'h0000;
      up_reg <= 1'b0;
    end else if (!run) begin // RL1
      cnt_reg <= sync_cfg_reg[RELOAD_LSB +: 16];
      up_reg <= 1'b0;
    end else if (sync_pulse) begin
      cnt_reg <= sync_cfg_reg[RELOAD_LSB +: 16]; // RL12
      up_reg <= 1'b0;
    end else if (!up_reg && cnt_reg == 16'h0000) begin
      up_reg <= 1'b1;
      cnt_reg <= 16'h0001;
    end else if (up_reg) begin
      if (cnt_reg != 16'hFFFF) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // one lost-sync event per miss, except at a zero limit, where it repeats each cycle once the count saturates; held until the next pulse or stop
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      lost_cnt_reg <= 16'h0000;
    end else if (!run || sync_pulse || !up_reg) begin
      lost_cnt_reg <= 16'h0000;
    end else if (lost_cnt_reg != 16'hFFFF) begin
      lost_cnt_reg <= lost_cnt_reg + 16'h0001;
    end
  end
  assign lost_hit = run && up_reg && !sync_pulse && lost_cnt_reg == lost_top - 16'h0001; // RL14

  assign ev_set[EV_DONE] = i_trim_done_ev;
  assign ev_set[EV_WARN] = i_trim_warn_ev;
  assign ev_set[EV_FAULT] = i_trim_range_ev;
  assign ev_set[EV_SYNC] = i_expected_sync_ev;
  assign ev_set[EV_LOST] = lost_hit;

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_reg <= '0;
    end else begin
      for (int i = 0; i < N_EV; i++) begin
        if (ev_set[i]) begin
          stat_reg[i] <= 1'b1;
        end else if (i_wr && i_addr == IRQ_STAT_OFF && i_wdata[i]) begin
          stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_reg <= '0;
    end else if (i_wr && i_addr == IRQ_MASK_OFF) begin
      mask_reg <= i_wdata[N_EV-1:0];
    end
  end

  // each flag gated by its enable; lost sync counts as an error
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_reg & mask_reg & {
        run_ctrl_reg[FAULT_EN_BIT], // RL3
        run_ctrl_reg[EXP_SYNC_EN_BIT], // RL2
        run_ctrl_reg[FAULT_EN_BIT],
        run_ctrl_reg[TRIM_WARN_EN_BIT], // RL4
        run_ctrl_reg[TRIM_DONE_EN_BIT]}); // RL5 RL15
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        RUN_CTRL_OFF: o_rdata <= run_ctrl_reg;
        SYNC_CFG_OFF: o_rdata <= sync_cfg_reg;
        IRQ_STAT_OFF: o_rdata <= {27'h0, stat_reg};
        IRQ_MASK_OFF: o_rdata <= {27'h0, mask_reg};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  assign o_counter_run = run;
  assign o_counter_reload = sync_cfg_reg[RELOAD_LSB +: 16];
  assign o_window_limit = sync_cfg_reg[WLIM_LSB +: 8];
  assign o_sync_pulse = sync_pulse;
  assign o_counter = cnt_reg;
  assign o_counter_up = up_reg;
  assign o_irq_en = run_ctrl_reg[3:0];

  // register file checks
  cfg_frozen_a: assert property ( // RL7
    @(posedge i_core_clk) disable iff (i_rst)
    run |=> $stable(sync_cfg_reg))
    else $error("config changed while running");
  cfg_write_a: assert property ( // RL7
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == SYNC_CFG_OFF && !run) |=> sync_cfg_reg == ($past(i_wdata) & SYNC_CFG_WMASK))
    else $error("config write lost while stopped");
  cfg_rsvd_a: assert property ( // RL6
    @(posedge i_core_clk) disable iff (i_rst)
    (sync_cfg_reg & ~SYNC_CFG_WMASK) == 32'h0000_0000)
    else $error("reserved config bit set");
  run_write_a: assert property ( // RL13
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == RUN_CTRL_OFF) |=> run_ctrl_reg == ($past(i_wdata) & RUN_CTRL_WMASK))
    else $error("run control write lost");
  ctrl_rsvd_a: assert property ( // RL13
    @(posedge i_core_clk) disable iff (i_rst)
    (run_ctrl_reg & ~RUN_CTRL_WMASK) == 32'h0000_0000)
    else $error("reserved control bit set");
  rd_cfg_a: assert property ( // RL11
    @(posedge i_core_clk) disable iff (i_rst)
    (i_rd && i_addr == SYNC_CFG_OFF) |=> o_rdata == $past(sync_cfg_reg))
    else $error("config read wrong");
  // source select and sync pulse checks
  rsvd_src_a: assert property ( // RL9
    @(posedge i_core_clk) disable iff (i_rst)
    (src == SRC_RSVD) |-> !sel_ref)
    else $error("reserved source passed");
  src_pin_a: assert property ( // RL9
    @(posedge i_core_clk) disable iff (i_rst)
    (src == SRC_PIN) |-> sel_ref == pin_sync_reg[1])
    else $error("pin source not selected");
  src_xtal_a: assert property ( // RL9
    @(posedge i_core_clk) disable iff (i_rst)
    (src == SRC_CRYSTAL) |-> sel_ref == xtal_sync_reg[1])
    else $error("crystal source not selected");
  src_alt_a: assert property ( // RL9
    @(posedge i_core_clk) disable iff (i_rst)
    (src == SRC_PIN_ALT) |-> sel_ref == pin_sync_reg[1])
    else $error("code 11 not acting as pin");
  pulse_run_a: assert property ( // RL1
    @(posedge i_core_clk) disable iff (i_rst)
    sync_pulse |-> $past(run))
    else $error("sync pulse while stopped");
  // calibration counter checks
  stop_hold_a: assert property ( // RL1
    @(posedge i_core_clk) disable iff (i_rst)
    !run |=> !up_reg && !o_sync_pulse)
    else $error("counter ran while stopped");
  cnt_stop_a: assert property ( // RL1
    @(posedge i_core_clk) disable iff (i_rst)
    !run |=> cnt_reg == $past(o_counter_reload))
    else $error("stopped counter not at reload");
  reload_load_a: assert property ( // RL12
    @(posedge i_core_clk) disable iff (i_rst)
    (run && sync_pulse) |=> cnt_reg == $past(o_counter_reload))
    else $error("reload not loaded");
  pulse_down_a: assert property ( // RL12
    @(posedge i_core_clk) disable iff (i_rst)
    (run && sync_pulse) |=> !up_reg)
    else $error("pulse did not restart down count");
  down_step_a: assert property ( // RL12
    @(posedge i_core_clk) disable iff (i_rst)
    (run && !sync_pulse && !up_reg && cnt_reg != 16'h0000) |=> cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("down count step wrong");
  turn_up_a: assert property ( // RL14
    @(posedge i_core_clk) disable iff (i_rst)
    (run && !sync_pulse && !up_reg && cnt_reg == 16'h0000) |=> up_reg)
    else $error("counter did not turn up at zero");
  up_step_a: assert property ( // RL14
    @(posedge i_core_clk) disable iff (i_rst)
    (run && !sync_pulse && up_reg && cnt_reg != 16'hFFFF) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("up count step wrong");
  lost_top_a: assert property ( // RL14
    @(posedge i_core_clk) disable iff (i_rst)
    (lost_hit && lost_top != 16'h0000) |-> cnt_reg == lost_top)
    else $error("lost sync at wrong count");
  lost_stat_a: assert property ( // RL14
    @(posedge i_core_clk) disable iff (i_rst)
    lost_hit |=> stat_reg[EV_LOST])
    else $error("lost sync flag not set");
  lost_irq_a: assert property ( // RL14
    @(posedge i_core_clk) disable iff (i_rst)
    (lost_hit && mask_reg[EV_LOST] && run_ctrl_reg[FAULT_EN_BIT]) |=> ##1 o_irq)
    else $error("lost sync raised no interrupt");
  // status flags
  done_set_a: assert property ( // RL5
    @(posedge i_core_clk) disable iff (i_rst)
    i_trim_done_ev |=> stat_reg[EV_DONE])
    else $error("done flag not set");
  warn_set_a: assert property ( // RL4
    @(posedge i_core_clk) disable iff (i_rst)
    i_trim_warn_ev |=> stat_reg[EV_WARN])
    else $error("warning flag not set");
  range_set_a: assert property ( // RL3
    @(posedge i_core_clk) disable iff (i_rst)
    i_trim_range_ev |=> stat_reg[EV_FAULT])
    else $error("range fault flag not set");
  sync_set_a: assert property ( // RL2
    @(posedge i_core_clk) disable iff (i_rst)
    i_expected_sync_ev |=> stat_reg[EV_SYNC])
    else $error("expected sync flag not set");
  stat_clr_a: assert property ( // RL15
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == IRQ_STAT_OFF && !(|ev_set))
      |=> stat_reg == ($past(stat_reg) & ~$past(i_wdata[N_EV-1:0])))
    else $error("status clear wrong");
  mask_wr_a: assert property ( // RL15
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == IRQ_MASK_OFF) |=> mask_reg == $past(i_wdata[N_EV-1:0]))
    else $error("mask write lost");
  // interrupt gating
  irq_src_a: assert property ( // RL15
    @(posedge i_core_clk) disable iff (i_rst)
    o_irq |-> $past(|(stat_reg & mask_reg)))
    else $error("irq without masked flag");
  irq_gate_a: assert property ( // RL15
    @(posedge i_core_clk) disable iff (i_rst)
    (run_ctrl_reg[3:0] == 4'h0) |=> !o_irq)
    else $error("irq with enables off");
  fault_gate_a: assert property ( // RL3
    @(posedge i_core_clk) disable iff (i_rst)
    (stat_reg[EV_FAULT] && mask_reg[EV_FAULT] && run_ctrl_reg[FAULT_EN_BIT]) |=> o_irq)
    else $error("fault irq missing");
  sync_gate_a: assert property ( // RL2
    @(posedge i_core_clk) disable iff (i_rst)
    (stat_reg == 5'h08 && !run_ctrl_reg[EXP_SYNC_EN_BIT]) |=> !o_irq)
    else $error("sync irq not gated");
  sync_on_a: assert property ( // RL2
    @(posedge i_core_clk) disable iff (i_rst)
    (stat_reg[EV_SYNC] && mask_reg[EV_SYNC] && run_ctrl_reg[EXP_SYNC_EN_BIT]) |=> o_irq)
    else $error("sync irq missing");
  done_gate_a: assert property ( // RL5
    @(posedge i_core_clk) disable iff (i_rst)
    (stat_reg == 5'h01 && !run_ctrl_reg[TRIM_DONE_EN_BIT]) |=> !o_irq)
    else $error("done irq not gated");
  warn_gate_a: assert property ( // RL4
    @(posedge i_core_clk) disable iff (i_rst)
    (stat_reg == 5'h02 && !run_ctrl_reg[TRIM_WARN_EN_BIT]) |=> !o_irq)
    else $error("warning irq not gated");
endmodule

// ---- pkg/trim_cfg_pkg.sv ----
// constants for the oscillator trim configuration block
package trim_cfg_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] RUN_CTRL_OFF = 4'h0;
  localparam logic [3:0] SYNC_CFG_OFF = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFF = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFF = 4'hC;
  // run control fields
  localparam int TRIM_DONE_EN_BIT = 0;
  localparam int TRIM_WARN_EN_BIT = 1;
  localparam int FAULT_EN_BIT = 2;
  localparam int EXP_SYNC_EN_BIT = 3;
  localparam int COUNTER_RUN_BIT = 5;
  localparam logic [31:0] RUN_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RUN_CTRL_WMASK = 32'h0000_002F;
  // sync config fields
  localparam int EDGE_BIT = 31;
  localparam int SRC_LSB = 28;
  localparam int DIV_LSB = 24;
  localparam int WLIM_LSB = 16;
  localparam int RELOAD_LSB = 0;
  localparam logic [31:0] SYNC_CFG_RST = 32'h2022_BB7F;
  localparam logic [31:0] SYNC_CFG_WMASK = 32'hB7FF_FFFF;
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_RSVD = 2'h2;
  localparam logic [1:0] SRC_PIN_ALT = 2'h3;
  // event status bits
  localparam int EV_DONE = 0;
  localparam int EV_WARN = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_SYNC = 3;
  localparam int EV_LOST = 4;
  localparam int N_EV = 5;
  localparam int LOST_MULT = 128;
endpackage

// ---- logic/sync_divider_unit.sv ----
// edge detect and power-of-two divider for the sync reference
module sync_divider_unit (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control
  input wire logic i_run,
  input wire logic i_edge_sel,
  input wire logic [2:0] i_div_code,
  // reference level, already synchronised
  input wire logic i_ref,
  // divided pulse
  output logic o_pulse
);
  logic ref_d_reg;
  logic [6:0] div_cnt_reg;
  logic edge_hit;
  logic [6:0] div_top;

  assign edge_hit = i_edge_sel ? (ref_d_reg & ~i_ref) : (~ref_d_reg & i_ref); // RL8
  assign div_top = 7'((8'h01 << i_div_code) - 8'h01); // RL10

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_d_reg <= 1'b0;
    end else begin
      ref_d_reg <= i_ref;
    end
  end

  // counter restarts when stopped so each run sees a full division
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_reg <= 7'h00;
      o_pulse <= 1'b0;
    end else if (!i_run) begin
      div_cnt_reg <= 7'h00;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= 1'b0;
      if (edge_hit) begin
        if (div_cnt_reg >= div_top) begin // RL10
          div_cnt_reg <= 7'h00;
          o_pulse <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 7'h01;
        end
      end
    end
  end
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the trim sync configuration block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import trim_cfg_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, pin = 0, xtal = 0;
  logic [3:0] addr = 4'h0;
  logic [3:0] ev = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic run, up, sp, irq;
  logic [15:0] rl, cnt;
  logic [7:0] wl;
  logic [3:0] ien;
  int err_total = 0, num_checks = 0, cyc = 0, npulse = 0, n;
  logic [31:0] cfg [9] = '{32'h0022BB7F, 32'h8022BB7F, 32'h3022BB7F, 32'h1022BB7F,
    32'h1022BB7F, 32'h2022BB7F, 32'h0122BB7F, 32'h0322BB7F, 32'h0222BB7F};
  logic usex [9] = '{0, 0, 0, 1, 0, 0, 0, 0, 0};
  int npx [9] = '{8, 7, 8, 8, 0, 0, 4, 1, 2};

  clock_trim_sync_config i_clock_trim_sync_config (.i_core_clk(clk), .i_rst(rst),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_sync_pin(pin),
    .i_low_speed_crystal(xtal), .i_trim_done_ev(ev[0]), .i_trim_warn_ev(ev[1]),
    .i_trim_range_ev(ev[2]), .i_expected_sync_ev(ev[3]), .o_counter_run(run),
    .o_counter_reload(rl), .o_window_limit(wl), .o_sync_pulse(sp), .o_counter(cnt),
    .o_counter_up(up), .o_irq_en(ien), .o_irq(irq));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // cut a hang short well past the expected run of about 1200 cycles
  always @(posedge clk) begin
    cyc++;
    if (sp === 1'b1)
      npulse++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wreg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(string what, logic [3:0] a, logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdat);
  endtask

  // irq is registered, so give it one cycle beyond the cause
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pulse_ev(int i);
    @(posedge clk) ev[i] <= 1'b1;
    @(posedge clk) ev[i] <= 1'b0;
    settle();
  endtask

  // 15 toggles from low: 8 rising and 7 falling edges
  task automatic edges(logic use_x);
    for (int k = 0; k < 15; k++) begin
      repeat (6) @(posedge clk);
      if (k == 0)
        npulse = 0;
      if (use_x)
        xtal <= ~xtal;
      else
        pin <= ~pin;
    end
    repeat (10) @(posedge clk);
    n = npulse;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reload", 32'hBB7F, {16'h0, rl});
    chk("limit", 32'h22, {24'h0, wl});
    chk("run", 32'h0, {31'h0, run});
    chk("irq", 32'h0, {31'h0, irq});
    rchk("ctrl", 4'h0, 32'h0);
    rchk("cfg", 4'h4, 32'h2022BB7F);
    rchk("unmapped", 4'h2, 32'h0);
    $display("test reset done");
    wreg(4'h4, 32'hFFFFFFFF);
    rchk("cfg wr", 4'h4, 32'hB7FFFFFF);
    wreg(4'h0, 32'hFFFFFFFF);
    rchk("ctrl wr", 4'h0, 32'h2F);
    chk("en", 32'hF, {28'h0, ien});
    chk("run", 32'h1, {31'h0, run});
    wreg(4'h4, 32'h0);
    rchk("cfg locked", 4'h4, 32'hB7FFFFFF);
    chk("locked rl", 32'hFFFF, {16'h0, rl});
    $display("test regs done");
    for (int c = 0; c < 9; c++) begin
      wreg(4'h0, 32'h0);
      pin <= 1'b0;
      xtal <= 1'b0;
      wreg(4'h4, cfg[c]);
      wreg(4'h0, 32'h20);
      edges(usex[c]);
      chk("pulses", npx[c], n);
    end
    $display("test sync done");
    wreg(4'h0, 32'h0);
    settle();
    chk("cnt stop", 32'hBB7F, {16'h0, cnt});
    wreg(4'hC, 32'h1F);
    for (int i = 0; i < 4; i++) begin
      pulse_ev(i);
      chk("irq off", 32'h0, {31'h0, irq});
      rchk("stat", 4'h8, 32'h1 << i);
      wreg(4'h0, 32'h1 << i);
      settle();
      chk("irq on", 32'h1, {31'h0, irq});
      wreg(4'hC, 32'h0);
      settle();
      chk("irq masked", 32'h0, {31'h0, irq});
      wreg(4'hC, 32'h1F);
      wreg(4'h8, 32'h1 << i);
      settle();
      chk("irq clr", 32'h0, {31'h0, irq});
      rchk("stat clr", 4'h8, 32'h0);
      wreg(4'h0, 32'h0);
    end
    $display("test irq done");
    // source code 10 gives no pulses, so the counter must run out
    wreg(4'h4, 32'h20010002);
    wreg(4'h0, 32'h24);
    repeat (118) @(posedge clk);
    rchk("lost early", 4'h8, 32'h0);
    repeat (20) @(posedge clk);
    rchk("lost", 4'h8, 32'h10);
    chk("up", 32'h1, {31'h0, up});
    chk("irq lost", 32'h1, {31'h0, irq});
    $display("test lost done");
    report_and_stop();
  end
endmodule
